//--- rtl/sce_pkg.sv
// package: constants and carriers for the slow-clock elapsed timer
package sce_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] SCE_OFS_MODE = 4'h0;
   localparam logic [3:0] SCE_OFS_MATCH = 4'h4;
   localparam logic [3:0] SCE_OFS_COUNT = 4'h8;
   localparam logic [3:0] SCE_OFS_FLAGS = 4'hc;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SCE_MODE_ALM_IE = 16;
   localparam int SCE_MODE_ROLL_IE = 17;
   localparam int SCE_MODE_RESTART = 18;
   localparam int SCE_MODE_DISABLE = 20;
   localparam int SCE_MODE_ONE_HZ = 24;
   localparam int SCE_FLAG_ALM = 0;
   localparam int SCE_FLAG_ROLL = 1;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [15:0] SCE_PRESCALE_RST = 16'h8000;
   localparam logic [31:0] SCE_MATCH_RST = 32'hffff_ffff;
   localparam logic [31:0] SCE_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] SCE_RDATA_RST = 32'h0000_0000;
   localparam logic [1:0] SCE_IRQ_HOLD_TICKS = 2'h2;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } sce_bus_req_type;

   typedef enum logic {
      SCE_BUS_IDLE = 1'b0,
      SCE_BUS_ANSWER = 1'b1
   } sce_bus_state_type;

endpackage : sce_pkg

//--- rtl/sce_edge_sync.sv
// rising-edge detector behind a two-stage synchroniser
`timescale 1ns/10ps
module sce_edge_sync (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_rise
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // only sync_q looks at meta_q
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         o_rise <= 1'b0;
      end else if (i_ce) begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
         o_rise <= sync_q & ~last_q;
      end
   end

endmodule : sce_edge_sync

//--- rtl/sce_prescaler.sv
// programmable 16-bit slow-clock divider
`timescale 1ns/10ps
module sce_prescaler (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_run,
   input wire logic i_reload,
   input wire logic [15:0] i_period,
   output logic o_roll
);

   logic [15:0] cnt_q;
   logic [15:0] last;

   // period 0 wraps to 16'hffff: a 65536-tick period
   assign last = i_period - 16'h1;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 16'h0;
         o_roll <= 1'b0;
      end else if (i_ce) begin
         if (i_reload) begin
            cnt_q <= 16'h0;
            o_roll <= 1'b0;
         end else if (i_run && i_tick) begin
            if (cnt_q == last) begin
               cnt_q <= 16'h0;
               o_roll <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'h1;
               o_roll <= 1'b0;
            end
         end else begin
            o_roll <= 1'b0;
         end
      end
   end

   a_roll_at_period: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && i_run && i_tick && !i_reload && cnt_q == last |=> o_roll && cnt_q == 16'h0
   ) else $error("prescaler missed its roll-over");

endmodule : sce_prescaler

//--- rtl/sce_timer_top.sv
// slow-clock elapsed timer: register slave, counter, alarm and interrupt
// ------------------------------------------------------------
// Function
// - 16-bit prescaler feeds a 32-bit up-counter
// - counter wraps to zero and keeps going
// - period is prescale value, zero means 65536
// - prescale resets to 0x8000
// - one-hertz select counts calendar ticks instead
// - roll-over flag set on every prescaler roll
// - interrupt returns two slow cycles after status read
// - alarm flag rises as count reaches match+1
// - match register resets to all ones
// - alarm flag always drives the wake-up output
// - status read clears the flags it returned set
// - restart reloads prescaler and zeroes counter
// - disable bit stops all counting
// - interrupt is flag and enable, either source
// - disable and one-hertz bits are write-only
// ------------------------------------------------------------
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
module sce_timer_top (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_slow_clock,
   input wire logic i_one_hertz_tick,
   input wire sce_pkg::sce_bus_req_type i_bus,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic o_irq,
   output logic o_alarm
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   sce_pkg::sce_bus_state_type bus_state_q;
   logic req;
   logic answer;
   logic [3:0] addr_w;
   logic wr_mode;
   logic wr_match;
   logic rd_status;
   logic [31:0] rd_mux;

   logic [15:0] prescale_q;
   logic alm_ie_q;
   logic roll_ie_q;
   logic restart_q;
   logic disable_q;
   logic one_hz_q;
   logic [31:0] match_q;
   logic [31:0] count_q;
   logic [1:0] flags_q;
   logic [1:0] flags_d;
   logic [1:0] flags_clr;
   logic [1:0] hold_q;

   logic slow_rise;
   logic hz_rise;
   logic roll;
   logic run;
   logic inc;
   logic alm_set;

   // ------------------------------------------------------------
   // pin sampling and prescaler
   // ------------------------------------------------------------
   sce_edge_sync u_slow_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_pin(i_slow_clock),
      .o_rise(slow_rise)
   );

   sce_edge_sync u_hz_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_pin(i_one_hertz_tick),
      .o_rise(hz_rise)
   );

   // the divider keeps running in one-hertz mode so roll-over flags still come
   sce_prescaler u_prescaler (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_tick(slow_rise),
      .i_run(run),
      .i_reload(restart_q),
      .i_period(prescale_q),
      .o_roll(roll)
   );

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   assign req = i_bus.read | i_bus.write;
   assign answer = (bus_state_q == sce_pkg::SCE_BUS_ANSWER);
   assign addr_w = {i_bus.address[3:2], 2'b00};
   assign wr_mode = answer && i_bus.write && addr_w == sce_pkg::SCE_OFS_MODE;
   assign wr_match = answer && i_bus.write && addr_w == sce_pkg::SCE_OFS_MATCH;
   assign rd_status = answer && i_bus.read && addr_w == sce_pkg::SCE_OFS_FLAGS;

   // one wait cycle: data is captured, then the access completes
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bus_state_q <= sce_pkg::SCE_BUS_IDLE;
         o_waitrequest <= 1'b1;
      end else if (i_ce) begin
         case (bus_state_q)
            sce_pkg::SCE_BUS_IDLE: begin
               if (req) begin
                  bus_state_q <= sce_pkg::SCE_BUS_ANSWER;
                  o_waitrequest <= 1'b0;
               end
            end
            sce_pkg::SCE_BUS_ANSWER: begin
               bus_state_q <= sce_pkg::SCE_BUS_IDLE;
               o_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_q <= sce_pkg::SCE_BUS_IDLE;
               o_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      case (addr_w)
         sce_pkg::SCE_OFS_MODE: begin
            rd_mux[15:0] = prescale_q;
            rd_mux[sce_pkg::SCE_MODE_ALM_IE] = alm_ie_q;
            rd_mux[sce_pkg::SCE_MODE_ROLL_IE] = roll_ie_q;
            // disable and one-hertz select read as zero
         end
         sce_pkg::SCE_OFS_MATCH: begin
            rd_mux = match_q;
         end
         sce_pkg::SCE_OFS_COUNT: begin
            rd_mux = count_q;
         end
         sce_pkg::SCE_OFS_FLAGS: begin
            rd_mux[1:0] = flags_q;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_readdata <= sce_pkg::SCE_RDATA_RST;
      end else if (i_ce && !answer && i_bus.read) begin
         o_readdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // mode and match registers
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prescale_q <= sce_pkg::SCE_PRESCALE_RST;
         alm_ie_q <= 1'b0;
         roll_ie_q <= 1'b0;
         disable_q <= 1'b0;
         one_hz_q <= 1'b0;
         restart_q <= 1'b0;
      end else if (i_ce) begin
         restart_q <= wr_mode && i_bus.byteenable[2]
            && i_bus.writedata[sce_pkg::SCE_MODE_RESTART];
         if (wr_mode && i_bus.byteenable[0]) begin
            prescale_q[7:0] <= i_bus.writedata[7:0];
         end
         if (wr_mode && i_bus.byteenable[1]) begin
            prescale_q[15:8] <= i_bus.writedata[15:8];
         end
         if (wr_mode && i_bus.byteenable[2]) begin
            alm_ie_q <= i_bus.writedata[sce_pkg::SCE_MODE_ALM_IE];
            roll_ie_q <= i_bus.writedata[sce_pkg::SCE_MODE_ROLL_IE];
            disable_q <= i_bus.writedata[sce_pkg::SCE_MODE_DISABLE];
         end
         if (wr_mode && i_bus.byteenable[3]) begin
            one_hz_q <= i_bus.writedata[sce_pkg::SCE_MODE_ONE_HZ];
         end
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_match_byte
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            match_q[8*b +: 8] <= sce_pkg::SCE_MATCH_RST[8*b +: 8];
         end else if (i_ce && wr_match && i_bus.byteenable[b]) begin
            match_q[8*b +: 8] <= i_bus.writedata[8*b +: 8];
         end
      end
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   assign run = !disable_q;
   assign inc = run && (one_hz_q ? hz_rise : roll);
   // flag rises with the increment that leaves the match value
   assign alm_set = inc && !restart_q && count_q == match_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_q <= sce_pkg::SCE_COUNT_RST;
      end else if (i_ce) begin
         if (restart_q) begin
            count_q <= sce_pkg::SCE_COUNT_RST;
         end else if (inc) begin
            count_q <= count_q + 32'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // flags, wake-up and interrupt
   // ------------------------------------------------------------
   // only bits actually returned are cleared; a same-cycle set wins
   assign flags_clr = rd_status ? o_readdata[1:0] : 2'b00;

   always_comb begin
      flags_d = flags_q & ~flags_clr;
      if (roll) begin
         flags_d[sce_pkg::SCE_FLAG_ROLL] = 1'b1;
      end
      if (alm_set) begin
         flags_d[sce_pkg::SCE_FLAG_ALM] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_q <= 2'b00;
         o_alarm <= 1'b0;
      end else if (i_ce) begin
         flags_q <= flags_d;
         o_alarm <= flags_d[sce_pkg::SCE_FLAG_ALM];
      end
   end

   // a status read masks the line for two slow-clock edges
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_q <= 2'h0;
      end else if (i_ce) begin
         if (rd_status) begin
            hold_q <= sce_pkg::SCE_IRQ_HOLD_TICKS;
         end else if (slow_rise && hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= hold_q == 2'h0 && !rd_status
            && ((flags_q[sce_pkg::SCE_FLAG_ALM] && alm_ie_q)
            || (flags_q[sce_pkg::SCE_FLAG_ROLL] && roll_ie_q));
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_count_wrap: assert property (
      i_ce && inc && !restart_q && count_q == 32'hffff_ffff |=> count_q == 32'h0
   ) else $error("counter did not wrap to zero");

   a_alarm_plus_one: assert property (
      $rose(flags_q[sce_pkg::SCE_FLAG_ALM]) |-> count_q == match_q + 32'h1
   ) else $error("alarm flag rose off match plus one");

   a_alarm_pin_holds: assert property (
      o_alarm && !rd_status |=> o_alarm
   ) else $error("wake-up output dropped without a status read");

   a_irq_cause: assert property (
      $rose(o_irq) |-> $past(flags_q[sce_pkg::SCE_FLAG_ALM] && alm_ie_q)
         || $past(flags_q[sce_pkg::SCE_FLAG_ROLL] && roll_ie_q)
   ) else $error("interrupt without enabled flag");

   a_irq_read_gap: assert property (
      i_ce && rd_status |=> !o_irq ##1 !o_irq
   ) else $error("interrupt too soon after status read");

   a_status_clear: assert property (
      i_ce && rd_status && !roll && !alm_set |=> (flags_q & $past(o_readdata[1:0])) == 2'b00
   ) else $error("status read did not clear flags");

   a_restart_zero: assert property (
      i_ce && restart_q |=> count_q == 32'h0
   ) else $error("restart did not zero the counter");

   a_disable_freeze: assert property (
      disable_q && !restart_q |=> $stable(count_q)
   ) else $error("counter moved while disabled");

   a_one_hz_step: assert property (
      i_ce && run && one_hz_q && hz_rise && !restart_q |=> count_q == $past(count_q) + 32'h1
   ) else $error("one-hertz tick did not step the counter");

   a_roll_flag: assert property (
      i_ce && roll |=> flags_q[sce_pkg::SCE_FLAG_ROLL]
   ) else $error("roll-over flag not set");

endmodule : sce_timer_top

//--- sim/tb_top.sv
// self-checking bench for the slow-clock elapsed timer
`timescale 1ns/10ps
module tb_top;
   logic i_mclk;
   logic i_rst_n;
   logic i_ce;
   logic i_slow_clock;
   logic i_one_hertz_tick;
   sce_pkg::sce_bus_req_type i_bus;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic o_irq;
   logic o_alarm;
   int err_total;
   int n_compared;
   int cyc;
   int edges;
   logic [31:0] rd;
   logic [15:0] pres;

   sce_timer_top uut (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_slow_clock(i_slow_clock),
      .i_one_hertz_tick(i_one_hertz_tick),
      .i_bus(i_bus),
      .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest),
      .o_irq(o_irq),
      .o_alarm(o_alarm)
   );

   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // hang guard: the whole sequence needs well under 10000 cycles
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // bus and pin drivers
   // ------------------------------------------------------------
   // request held until waitrequest is seen low at a rising edge; data taken there
   task automatic bus(input logic wr_en, input logic [3:0] adr, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rdat);
      @(posedge i_mclk);
      i_bus <= {~wr_en, wr_en, adr, wd, be};
      do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
      rdat = o_readdata;
      i_bus <= '0;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf, rd);
   endtask : wr

   task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] prev;
      bus(1'b0, a, 32'h0, 4'h0, rd);
      // count moves with the slow clock: read again until two reads agree
      if (a == sce_pkg::SCE_OFS_COUNT) begin
         do begin
            prev = rd;
            bus(1'b0, a, 32'h0, 4'h0, rd);
         end while (rd !== prev);
      end
      check(what, rd, e);
   endtask : rchk

   task automatic pin_chk(input bit alarm, input logic e);
      @(negedge i_mclk);
      check(alarm ? "alarm" : "irq", {31'h0, alarm ? o_alarm : o_irq}, {31'h0, e});
   endtask : pin_chk

   // tail covers the synchroniser, roll and increment latency
   task automatic pulse(input bit hz, input int n);
      repeat (n) begin
         @(posedge i_mclk);
         if (hz) i_one_hertz_tick <= 1'b1;
         else i_slow_clock <= 1'b1;
         repeat (4) @(posedge i_mclk);
         i_one_hertz_tick <= 1'b0;
         i_slow_clock <= 1'b0;
         repeat (3) @(posedge i_mclk);
      end
      repeat (6) @(posedge i_mclk);
   endtask : pulse

   function automatic logic [31:0] mode(input logic [15:0] p, input logic [31:0] bits);
      return bits | (32'h1 << sce_pkg::SCE_MODE_RESTART) | {16'h0, p};
   endfunction : mode

   function automatic logic [31:0] exp_count(input int n, input logic [15:0] p);
      return 32'(n / ((p == 16'h0) ? 65536 : int'(p)));
   endfunction : exp_count

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_slow_clock = 1'b0;
      i_one_hertz_tick = 1'b0;
      i_bus = '0;
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      void'($urandom(32'h229f));
      repeat (3) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rchk("mode", sce_pkg::SCE_OFS_MODE, 32'h0000_8000);
      rchk("match", sce_pkg::SCE_OFS_MATCH, 32'hffff_ffff);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h0);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h0);
      wr(sce_pkg::SCE_OFS_COUNT, 32'h55);
      wr(sce_pkg::SCE_OFS_FLAGS, 32'h3);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h0);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h0);
      // write-only selects and restart never read back
      wr(sce_pkg::SCE_OFS_MODE, 32'h0117_0005);
      rchk("mode", sce_pkg::SCE_OFS_MODE, 32'h0003_0005);
      // enables dropped through one byte lane before the prescale changes
      bus(1'b1, sce_pkg::SCE_OFS_MODE, 32'h0, 4'h4, rd);
      rchk("mode", sce_pkg::SCE_OFS_MODE, 32'h0000_0005);
      // random prescale and tick counts
      for (int k = 0; k < 5; k++) begin
         pres = 16'(3 + $urandom_range(5));
         edges = int'($urandom_range(13));
         wr(sce_pkg::SCE_OFS_MODE, mode(pres, 32'h0));
         pulse(1'b0, edges);
         rchk("count", sce_pkg::SCE_OFS_COUNT, exp_count(edges, pres));
         rchk("flags", sce_pkg::SCE_OFS_FLAGS, {30'h0, edges >= int'(pres), 1'b0});
      end
      // disable freezes the counter
      wr(sce_pkg::SCE_OFS_MODE, mode(16'h3, 32'h0));
      pulse(1'b0, 3);
      wr(sce_pkg::SCE_OFS_MODE, 32'h0010_0003);
      pulse(1'b0, 6);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h1);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h2);
      // roll interrupt, masked after the status read
      wr(sce_pkg::SCE_OFS_MODE, mode(16'h3, 32'h0002_0000));
      pulse(1'b0, 3);
      pin_chk(1'b0, 1'b1);
      // handler masks the line, clears status, then unmasks
      bus(1'b1, sce_pkg::SCE_OFS_MODE, 32'h0, 4'h4, rd);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h2);
      bus(1'b1, sce_pkg::SCE_OFS_MODE, 32'h0002_0000, 4'h4, rd);
      pin_chk(1'b0, 1'b0);
      pulse(1'b0, 3);
      pin_chk(1'b0, 1'b1);
      bus(1'b1, sce_pkg::SCE_OFS_MODE, 32'h0, 4'h4, rd);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h2);
      pin_chk(1'b0, 1'b0);
      // alarm one past match, enables off
      wr(sce_pkg::SCE_OFS_MATCH, 32'h4);
      rchk("match", sce_pkg::SCE_OFS_MATCH, 32'h4);
      wr(sce_pkg::SCE_OFS_MODE, mode(16'h3, 32'h0));
      pulse(1'b0, 12);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h4);
      pin_chk(1'b1, 1'b0);
      pulse(1'b0, 3);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h5);
      pin_chk(1'b1, 1'b1);
      pin_chk(1'b0, 1'b0);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h3);
      pin_chk(1'b1, 1'b0);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h0);
      // calendar tick source: prescaler rolls but does not step
      wr(sce_pkg::SCE_OFS_MODE, mode(16'h3, 32'h0100_0000));
      pulse(1'b0, 7);
      pulse(1'b1, 2);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h2);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h2);
      // clock enable low: pin edges, restart and counter all frozen
      wr(sce_pkg::SCE_OFS_MODE, mode(16'h3, 32'h0));
      i_ce <= 1'b0;
      pulse(1'b0, 6);
      i_ce <= 1'b1;
      pulse(1'b0, 3);
      rchk("count", sce_pkg::SCE_OFS_COUNT, 32'h1);
      rchk("flags", sce_pkg::SCE_OFS_FLAGS, 32'h2);
      wrap_up();
   end
endmodule : tb_top
